// *** hdl/fsp_pkg.sv ***
// Shared constants for the flash self-programming controller.
package fsp_pkg;
    // Register indices on the plain register port.
    localparam logic [2:0] REG_PTR_BOTTOM = 3'h0;
    localparam logic [2:0] REG_PTR_MID = 3'h1;
    localparam logic [2:0] REG_PTR_TOP = 3'h2;
    localparam logic [2:0] REG_LATCH = 3'h3;
    localparam logic [2:0] REG_CONTROL = 3'h4;
    localparam logic [2:0] REG_UNLOCK = 3'h5;
    localparam logic [2:0] REG_STATUS = 3'h6;
    // Control and status register field positions.
    localparam int CTL_PROG_SPACE = 7;
    localparam int CTL_CFG_SPACE = 6;
    localparam int CTL_ERASE_SEL = 4;
    localparam int CTL_ABORT = 3;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_START = 1;
    localparam int STS_DONE = 0;
    // Pointer and block geometry.
    localparam int PTR_W = 22;
    localparam int SPAN_W = 21;
    localparam int BLK_LSB = 6;
    localparam int BLK_BYTES = 64;
    // Unlock key bytes.
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // Value of an untouched holding byte.
    localparam logic [7:0] HOLD_BLANK = 8'hff;
    // Table pointer update modes.
    localparam logic [1:0] MODE_KEEP = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC = 2'h3;
    // Long cycle timing.
    localparam int CLK_MHZ = 200;
    localparam int ERASE_TIME_US = 2000;
    localparam int PROG_TIME_US = 2000;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // Controller states.
    typedef enum logic [3:0] {
        FSP_IDLE = 4'b0001,
        FSP_READ = 4'b0010,
        FSP_STREAM = 4'b0100,
        FSP_TIMED = 4'b1000
    } fsp_state_t;
endpackage

// *** hdl/fsp_hold_buf.sv ***
// Write-block holding buffer: one byte per block byte, blank after reset or clear.
`timescale 1ns/1ps
module fsp_hold_buf #(
    parameter int DEPTH = fsp_pkg::BLK_BYTES,
    parameter int IDX_W = 6
) (
    // Clocking.
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Byte load from the table latch.
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Return every byte to blank.
    input wire logic clear_all,
    // Read side for the programming stream.
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    // Clear wins over a load; both only happen with the core stalled apart.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= fsp_pkg::HOLD_BLANK;
        end
        else if (ce)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (clear_all)
                    mem[i] <= fsp_pkg::HOLD_BLANK;
                else if (wr_en && wr_idx == IDX_W'(i))
                    mem[i] <= wr_data;
            end
        end
    end

    // Combinational read; the caller registers the result.
    assign rd_data = mem[rd_idx];
endmodule

// *** hdl/fsp_ctrl.sv ***
// Flash self-programming controller: table pointer, latch, holding block and long cycles.
// Functional notes
// - Pointer is 22 bits from top, mid and bottom byte registers.
// - Top pointer bit steers reads to identification and configuration space.
// - Table pointer auto-update changes only the low 21 bits.
// - Table read uses all 22 pointer bits and loads the latch.
// - Table write copies the latch into the holding byte picked by low bits.
// - Program write sends the whole holding block to the pointer's block.
// - Erase selects a block by pointer bits 21..6, ignoring bits 5..0.
// - Four pointer modes: keep, post-increment, post-decrement, pre-increment.
// - One byte per read; address bit 0 picks low or high word byte.
// - Erase always clears one 64-byte block; no word or bulk erase.
// - Long cycles start only after 55h, 0AAh unlock writes then start.
// - Core stalls during a long cycle; the timer ends it.
// - Block erase stalls the core for about 2 ms.
// - Programming streams a 64-byte block but writes only the non-blank holding bytes.
// - Holding bytes reset to FFh and after programming; FFh leaves flash.
// - Programming only clears bits; partial holding blocks are allowed.
// - Start bit is set-only by software and cleared by hardware at end.
// - Completion sets a sticky done flag until software clears it.
// - Abort flag set by a soft reset during a cycle or improper start, cleared by normal finish.
// - Unlock register stores nothing and reads as zero.
`timescale 1ns/1ps
module fsp_ctrl #(
    parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
    // Clock, reset and freeze.
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic soft_reset,
    // Register port.
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Table instructions from the core.
    input wire logic tbl_valid,
    input wire logic tbl_write,
    input wire logic [1:0] tbl_mode,
    output logic tbl_ack,
    output logic core_stall,
    // Flash array side.
    output logic [21:0] arr_addr,
    output logic arr_rd,
    input wire logic [15:0] arr_rdata,
    output logic arr_erase,
    output logic arr_prog_en,
    output logic [15:0] arr_blk,
    output logic [5:0] arr_prog_idx,
    output logic [7:0] arr_prog_data
);
    fsp_pkg::fsp_state_t state, next_state;
    logic [21:0] byte_pointer;
    logic [7:0] transfer_latch;
    logic program_space_select, config_space_select, erase_sel, write_permit;
    logic cycle_abort_flag, start_bit, cycle_done_flag, read_lsb;
    logic [1:0] unlock_stage;
    logic [6:0] stream_cnt;
    logic [31:0] timer;

    // Adds a signed step to the low 21 bits while the top bit stays put.
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic dec);
        logic [20:0] low;
        low = dec ? p[20:0] - 21'h1 : p[20:0] + 21'h1;
        return {p[21], low};
    endfunction

    // Decodes.
    wire idle = (state == fsp_pkg::FSP_IDLE);
    wire reg_acc = ce && (reg_wr || reg_rd);
    wire wr_ctl = ce && reg_wr && reg_addr == fsp_pkg::REG_CONTROL;
    wire wr_unl = ce && reg_wr && reg_addr == fsp_pkg::REG_UNLOCK;
    wire wr_sts = ce && reg_wr && reg_addr == fsp_pkg::REG_STATUS;
    wire tbl_take = ce && idle && tbl_valid && !start_bit && !soft_reset;
    wire start_req = wr_ctl && reg_wdata[fsp_pkg::CTL_START] && !start_bit;
    wire start_ok = start_req && !soft_reset && unlock_stage == 2'h2
        && reg_wdata[fsp_pkg::CTL_PERMIT] && reg_wdata[fsp_pkg::CTL_PROG_SPACE]
        && !reg_wdata[fsp_pkg::CTL_CFG_SPACE];
    wire start_bad = start_req && !start_ok;
    wire timer_zero = (timer == 32'h0);
    wire cycle_end = ce && state == fsp_pkg::FSP_TIMED && timer_zero && !soft_reset;
    wire cut_short = ce && soft_reset && start_bit;
    wire done_clr = wr_sts && !reg_wdata[fsp_pkg::STS_DONE];
    // Pre-increment uses the stepped pointer for the access itself.
    wire [21:0] eff_ptr = (tbl_mode == fsp_pkg::MODE_PRE_INC) ? ptr_step(byte_pointer, 1'b0)
        : byte_pointer;
    wire [21:0] next_ptr = (tbl_mode == fsp_pkg::MODE_POST_INC) ? ptr_step(byte_pointer, 1'b0)
        : (tbl_mode == fsp_pkg::MODE_POST_DEC) ? ptr_step(byte_pointer, 1'b1)
        : eff_ptr;
    wire [15:0] ptr_blk = byte_pointer[21:6];
    wire [7:0] hold_byte;
    wire [7:0] ctl_view = {program_space_select, config_space_select, 1'b0, erase_sel,
        cycle_abort_flag, write_permit, start_bit, 1'b0};
    wire [7:0] rd_mux = (reg_addr == fsp_pkg::REG_PTR_BOTTOM) ? byte_pointer[7:0]
        : (reg_addr == fsp_pkg::REG_PTR_MID) ? byte_pointer[15:8]
        : (reg_addr == fsp_pkg::REG_PTR_TOP) ? {2'h0, byte_pointer[21:16]}
        : (reg_addr == fsp_pkg::REG_LATCH) ? transfer_latch
        : (reg_addr == fsp_pkg::REG_CONTROL) ? ctl_view
        : (reg_addr == fsp_pkg::REG_STATUS) ? {7'h0, cycle_done_flag}
        : 8'h00;

    fsp_hold_buf #(.DEPTH(fsp_pkg::BLK_BYTES), .IDX_W(6)) u_hold (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .wr_en(tbl_take && tbl_write),
        .wr_idx(eff_ptr[5:0]),
        .wr_data(transfer_latch),
        .clear_all(cycle_end && !erase_sel),
        .rd_idx(stream_cnt[5:0]),
        .rd_data(hold_byte)
    );

    // Sequencer: a read waits one cycle for the array, a program streams 64 bytes.
    always_comb
    begin
        next_state = state;
        unique case (state)
            fsp_pkg::FSP_IDLE:
                if (start_ok)
                    next_state = reg_wdata[fsp_pkg::CTL_ERASE_SEL] ? fsp_pkg::FSP_TIMED
                        : fsp_pkg::FSP_STREAM;
                else if (tbl_take && !tbl_write)
                    next_state = fsp_pkg::FSP_READ;
            fsp_pkg::FSP_READ:
                next_state = fsp_pkg::FSP_IDLE;
            fsp_pkg::FSP_STREAM:
                if (stream_cnt == 7'(fsp_pkg::BLK_BYTES - 1))
                    next_state = fsp_pkg::FSP_TIMED;
            fsp_pkg::FSP_TIMED:
                if (timer_zero)
                    next_state = fsp_pkg::FSP_IDLE;
        endcase
        if (soft_reset)
            next_state = fsp_pkg::FSP_IDLE;
    end

    // State, stream counter and programming timer.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= fsp_pkg::FSP_IDLE;
            stream_cnt <= 7'h0;
            timer <= 32'h0;
        end
        else if (ce)
        begin
            state <= next_state;
            stream_cnt <= (state == fsp_pkg::FSP_STREAM) ? stream_cnt + 7'h1 : 7'h0;
            if (start_ok)
                timer <= reg_wdata[fsp_pkg::CTL_ERASE_SEL] ? 32'(ERASE_CYCLES - 1)
                    : 32'(PROG_CYCLES - 1);
            else if (state == fsp_pkg::FSP_TIMED && !timer_zero)
                timer <= timer - 32'h1;
        end
    end

    // Table pointer; a pointer byte write wins over a table update in the same cycle.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            byte_pointer <= 22'h0;
        else if (ce && reg_wr && reg_addr == fsp_pkg::REG_PTR_BOTTOM)
            byte_pointer[7:0] <= reg_wdata;
        else if (ce && reg_wr && reg_addr == fsp_pkg::REG_PTR_MID)
            byte_pointer[15:8] <= reg_wdata;
        else if (ce && reg_wr && reg_addr == fsp_pkg::REG_PTR_TOP)
            byte_pointer[21:16] <= reg_wdata[5:0];
        else if (tbl_take)
            byte_pointer <= next_ptr;
    end

    // Table latch: software writes it, or a read brings the chosen word byte.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            transfer_latch <= 8'h00;
        else if (ce && state == fsp_pkg::FSP_READ)
            transfer_latch <= read_lsb ? arr_rdata[15:8] : arr_rdata[7:0];
        else if (ce && reg_wr && reg_addr == fsp_pkg::REG_LATCH)
            transfer_latch <= reg_wdata;
    end

    // Array read request: all 22 bits go out, bit 21 selects configuration space.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            arr_addr <= 22'h0;
            arr_rd <= 1'b0;
            read_lsb <= 1'b0;
        end
        else if (ce)
        begin
            arr_rd <= tbl_take && !tbl_write;
            if (tbl_take && !tbl_write)
            begin
                arr_addr <= eff_ptr;
                read_lsb <= eff_ptr[0];
            end
        end
    end

    // Unlock tracker; only the exact three-step order survives.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            unlock_stage <= 2'h0;
        else if (wr_unl && unlock_stage == 2'h0 && reg_wdata == fsp_pkg::KEY_FIRST)
            unlock_stage <= 2'h1;
        else if (wr_unl && unlock_stage == 2'h1 && reg_wdata == fsp_pkg::KEY_SECOND)
            unlock_stage <= 2'h2;
        else if (reg_acc)
            unlock_stage <= 2'h0;
    end

    // Control bits. Start is set-only; erase select drops when an erase ends.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            program_space_select <= 1'b0;
            config_space_select <= 1'b0;
            erase_sel <= 1'b0;
            write_permit <= 1'b0;
            start_bit <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctl && !start_bit)
            begin
                program_space_select <= reg_wdata[fsp_pkg::CTL_PROG_SPACE];
                config_space_select <= reg_wdata[fsp_pkg::CTL_CFG_SPACE];
                erase_sel <= reg_wdata[fsp_pkg::CTL_ERASE_SEL];
                write_permit <= reg_wdata[fsp_pkg::CTL_PERMIT];
            end
            else if (cycle_end && erase_sel)
                erase_sel <= 1'b0;
            if (start_ok)
                start_bit <= 1'b1;
            else if (cycle_end || soft_reset)
                start_bit <= 1'b0;
        end
    end

    // Abort and done flags; hardware setting wins over a software clear.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cycle_abort_flag <= 1'b0;
            cycle_done_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (start_bad || cut_short)
                cycle_abort_flag <= 1'b1;
            else if (cycle_end)
                cycle_abort_flag <= 1'b0;
            else if (wr_ctl && !start_bit)
                cycle_abort_flag <= reg_wdata[fsp_pkg::CTL_ABORT];
            if (cycle_end)
                cycle_done_flag <= 1'b1;
            else if (done_clr)
                cycle_done_flag <= 1'b0;
        end
    end

    // Outputs toward the core and the array, all registered.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
            tbl_ack <= 1'b0;
            core_stall <= 1'b0;
            arr_erase <= 1'b0;
            arr_prog_en <= 1'b0;
            arr_blk <= 16'h0;
            arr_prog_idx <= 6'h0;
            arr_prog_data <= 8'h00;
        end
        else if (ce)
        begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            tbl_ack <= (tbl_take && tbl_write) || state == fsp_pkg::FSP_READ;
            core_stall <= start_ok || (start_bit && !cycle_end && !soft_reset);
            arr_erase <= start_ok && reg_wdata[fsp_pkg::CTL_ERASE_SEL];
            if (start_ok)
                arr_blk <= ptr_blk;
            // Blank bytes are skipped so their flash bytes stay as they are.
            arr_prog_en <= state == fsp_pkg::FSP_STREAM && !soft_reset
                && hold_byte != fsp_pkg::HOLD_BLANK;
            arr_prog_idx <= stream_cnt[5:0];
            arr_prog_data <= hold_byte;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_unlock_order: assert property ($rose(start_bit) |-> $past(unlock_stage) == 2'h2)
        else $error("start bit rose without a full unlock");
    a_start_held: assert property (start_bit && !cycle_end && !soft_reset |=> start_bit)
        else $error("start bit dropped before the timed cycle ended");
    a_stall_ties: assert property (core_stall == start_bit)
        else $error("core stall and start bit disagree");
    a_top_bit_kept: assert property (tbl_take && !reg_wr |=> $stable(byte_pointer[21]))
        else $error("table update changed the top pointer bit");
    a_done_sticky: assert property (cycle_done_flag && ce && !done_clr |=> cycle_done_flag)
        else $error("done flag lost without a clear");
    a_abort_cleared: assert property (cycle_end |=> !cycle_abort_flag && cycle_done_flag)
        else $error("normal finish left abort set or done clear");
    a_unlock_reads: assert property (ce && reg_rd && reg_addr == fsp_pkg::REG_UNLOCK
        |=> reg_rdata == 8'h00)
        else $error("unlock register read nonzero");
    a_unlock_voided: assert property (ce && unlock_stage == 2'h1 && reg_acc && !wr_unl
        |=> unlock_stage == 2'h0)
        else $error("unlock survived a foreign access");
    a_erase_block: assert property (start_ok && reg_wdata[fsp_pkg::CTL_ERASE_SEL]
        |=> arr_erase && arr_blk == $past(ptr_blk))
        else $error("erase block address wrong");
    a_read_latch: assert property (ce && state == fsp_pkg::FSP_READ ##1 1
        |-> transfer_latch == ($past(read_lsb) ? $past(arr_rdata[15:8]) : $past(arr_rdata[7:0])))
        else $error("read latch took the wrong byte");

    c_erase_done: cover property (cycle_end && erase_sel);
    c_prog_done: cover property (cycle_end && !erase_sel);
    c_bad_start: cover property (start_bad);
    c_table_read: cover property (state == fsp_pkg::FSP_READ);
endmodule

// *** sim/fsp_flash_model.sv ***
// Behavioural flash array that answers table reads and applies erase and program pulses.
`timescale 1ns/1ps
module fsp_flash_model (
    // Clock.
    input wire logic clock,
    // Read side.
    input wire logic [21:0] arr_addr,
    input wire logic arr_rd,
    output logic [15:0] arr_rdata,
    // Erase and program side.
    input wire logic arr_erase,
    input wire logic arr_prog_en,
    input wire logic [15:0] arr_blk,
    input wire logic [5:0] arr_prog_idx,
    input wire logic [7:0] arr_prog_data
);
    logic [7:0] mem [logic [21:0]];
    logic flip = 1'b0;
    int n_erase = 0;
    int n_prog = 0;
    logic [15:0] last_blk = 16'h0000;

    // Unwritten bytes hold an address pattern, so a missed erase or program shows up.
    function automatic logic [7:0] peek(input logic [21:0] a);
        return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h3c);
    endfunction

    // A word stands only with the read strobe; otherwise the bus toggles every cycle.
    always @*
    begin
        if (arr_rd)
            arr_rdata = {peek({arr_addr[21:1], 1'b1}), peek({arr_addr[21:1], 1'b0})};
        else
            arr_rdata = {16{flip}};
    end

    // Erase blanks a whole block; programming can only pull bits low.
    always @(posedge clock)
    begin
        flip <= ~flip;
        if (arr_erase)
        begin
            for (int i = 0; i < 64; i++)
                mem[{arr_blk, i[5:0]}] = 8'hff;
            n_erase++;
            last_blk = arr_blk;
        end
        if (arr_prog_en)
        begin
            mem[{arr_blk, arr_prog_idx}] = peek({arr_blk, arr_prog_idx}) & arr_prog_data;
            n_prog++;
            last_blk = arr_blk;
        end
    end
endmodule

// *** sim/flash_self_programming_ctrl_test.sv ***
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/1ps
module flash_self_programming_ctrl_test;
    localparam int EC = 20;
    localparam int PC = 20;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic soft_reset = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic tbl_valid = 1'b0;
    logic tbl_write = 1'b0;
    logic [1:0] tbl_mode = 2'h0;
    logic tbl_ack, core_stall, arr_rd, arr_erase, arr_prog_en;
    logic [21:0] arr_addr;
    logic [15:0] arr_rdata, arr_blk;
    logic [5:0] arr_prog_idx;
    logic [7:0] arr_prog_data;
    logic [21:0] seen_addr = 22'h0;
    int stall_cnt = 0;
    int n_errors = 0;
    int checks_done = 0;

    fsp_ctrl #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) i_fsp_ctrl (.clock(clock), .rstn(rstn),
        .ce(ce), .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tbl_valid(tbl_valid),
        .tbl_write(tbl_write), .tbl_mode(tbl_mode), .tbl_ack(tbl_ack), .core_stall(core_stall),
        .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_rdata(arr_rdata), .arr_erase(arr_erase),
        .arr_prog_en(arr_prog_en), .arr_blk(arr_blk), .arr_prog_idx(arr_prog_idx),
        .arr_prog_data(arr_prog_data));

    fsp_flash_model i_fsp_flash_model (.clock(clock), .arr_addr(arr_addr), .arr_rd(arr_rd),
        .arr_rdata(arr_rdata), .arr_erase(arr_erase), .arr_prog_en(arr_prog_en),
        .arr_blk(arr_blk), .arr_prog_idx(arr_prog_idx), .arr_prog_data(arr_prog_data));

    // A 5 ns clock, and a stall counter that times each long cycle.
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (core_stall === 1'b1)
            stall_cnt <= stall_cnt + 1;
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check22(input logic [21:0] got, input logic [21:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port: one-cycle strobes, read data stands in the following cycle only.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check8(d, exp);
    endtask
    task automatic set_ptr(input logic [21:0] p);
        wr(fsp_pkg::REG_PTR_TOP, {2'b00, p[21:16]});
        wr(fsp_pkg::REG_PTR_MID, p[15:8]);
        wr(fsp_pkg::REG_PTR_BOTTOM, p[7:0]);
    endtask
    task automatic ptr_chk(input logic [21:0] p);
        rd_chk(fsp_pkg::REG_PTR_TOP, {2'b00, p[21:16]});
        rd_chk(fsp_pkg::REG_PTR_MID, p[15:8]);
        rd_chk(fsp_pkg::REG_PTR_BOTTOM, p[7:0]);
    endtask

    // One table operation; the array address is caught while the read strobe stands.
    task automatic tbl(input logic w, input logic [1:0] m);
        int n;
        seen_addr = 22'h0;
        @(posedge clock);
        tbl_valid <= 1'b1;
        tbl_write <= w;
        tbl_mode <= m;
        @(posedge clock);
        tbl_valid <= 1'b0;
        n = 0;
        #1;
        while (tbl_ack !== 1'b1 && n < 4)
        begin
            if (arr_rd === 1'b1)
                seen_addr = arr_addr;
            @(posedge clock);
            #1;
            n++;
        end
        check8({7'h0, tbl_ack}, 8'h01);
    endtask
    task automatic rd_flash(input logic [21:0] a, input logic [7:0] exp);
        set_ptr(a);
        tbl(1'b0, fsp_pkg::MODE_KEEP);
        rd_chk(fsp_pkg::REG_LATCH, exp);
    endtask

    // Guarded start; a software clear of the start bit mid-cycle must not end it.
    task automatic launch(input logic [7:0] ctl, input int min);
        logic [7:0] d;
        int n;
        wr(fsp_pkg::REG_UNLOCK, fsp_pkg::KEY_FIRST);
        wr(fsp_pkg::REG_UNLOCK, fsp_pkg::KEY_SECOND);
        stall_cnt = 0;
        wr(fsp_pkg::REG_CONTROL, ctl);
        wr(fsp_pkg::REG_CONTROL, 8'h00);
        rd(fsp_pkg::REG_CONTROL, d);
        check8(d & 8'h02, 8'h02);
        n = 0;
        while (core_stall === 1'b1 && n < 2000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check8({7'h0, stall_cnt >= min && stall_cnt <= min + 8}, 8'h01);
        rd(fsp_pkg::REG_CONTROL, d);
        check8(d & 8'h1a, 8'h00);
        rd_chk(fsp_pkg::REG_STATUS, 8'h01);
        wr(fsp_pkg::REG_STATUS, 8'h00);
        rd_chk(fsp_pkg::REG_STATUS, 8'h00);
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // The whole run needs about a thousand cycles; this limit leaves ample margin.
    initial
    begin
        repeat (40000) @(posedge clock);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        logic [7:0] d;
        static logic [21:0] p0 [4] = '{22'h000100, 22'h3fffff, 22'h200000, 22'h00002f};
        static logic [21:0] pa [4] = '{22'h000100, 22'h3fffff, 22'h200000, 22'h000030};
        static logic [21:0] p1 [4] = '{22'h000100, 22'h200000, 22'h3fffff, 22'h000030};
        static logic [7:0] pd [4] = '{8'h0f, 8'h5a, 8'h00, 8'hff};
        static logic [21:0] pp [4] = '{22'h00137e, 22'h00137f, 22'h001340, 22'h001341};
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd_chk(a[2:0], 8'h00);
        wr(fsp_pkg::REG_PTR_TOP, 8'hff);
        rd_chk(fsp_pkg::REG_PTR_TOP, 8'h3f);
        // Every pointer mode, including wrap of the low 21 bits under a set top bit.
        for (int m = 0; m < 4; m++)
        begin
            set_ptr(p0[m]);
            tbl(1'b0, m[1:0]);
            check22(seen_addr, pa[m]);
            rd_chk(fsp_pkg::REG_LATCH, pa[m][7:0] ^ 8'h3c);
            ptr_chk(p1[m]);
        end
        // Broken unlock sequences must not start a cycle and must flag the attempt.
        set_ptr(22'h001345);
        for (int k = 0; k < 2; k++)
        begin
            wr(fsp_pkg::REG_UNLOCK, k == 0 ? fsp_pkg::KEY_FIRST : fsp_pkg::KEY_SECOND);
            if (k == 0)
                rd_chk(fsp_pkg::REG_STATUS, 8'h00);
            wr(fsp_pkg::REG_UNLOCK, k == 0 ? fsp_pkg::KEY_SECOND : fsp_pkg::KEY_FIRST);
            wr(fsp_pkg::REG_CONTROL, 8'h96);
            #1;
            check8({7'h0, core_stall}, 8'h00);
            rd(fsp_pkg::REG_CONTROL, d);
            check8(d & 8'h0a, 8'h08);
        end
        // Block erase picks the block from bits 21..6 only.
        launch(8'h96, EC);
        check8(8'(i_fsp_flash_model.n_erase), 8'h01);
        check22({6'h0, i_fsp_flash_model.last_blk}, 22'h00004d);
        rd_flash(22'h001340, 8'hff);
        rd_flash(22'h00137f, 8'hff);
        rd_flash(22'h00133f, 8'h03);
        rd_flash(22'h001380, 8'hbc);
        // Partial load that wraps the in-block index; the block comes from the pointer.
        set_ptr(22'h00133e);
        for (int i = 0; i < 4; i++)
        begin
            wr(fsp_pkg::REG_LATCH, pd[i]);
            tbl(1'b1, fsp_pkg::MODE_POST_INC);
        end
        launch(8'h86, PC + 64);
        check8(8'(i_fsp_flash_model.n_prog), 8'h03);
        check22({6'h0, i_fsp_flash_model.last_blk}, 22'h00004d);
        for (int i = 0; i < 4; i++)
            rd_flash(pp[i], pd[i]);
        // Holding bytes are blank again, so a one-byte reload programs one byte only.
        set_ptr(22'h00137e);
        wr(fsp_pkg::REG_LATCH, 8'hf0);
        tbl(1'b1, fsp_pkg::MODE_KEEP);
        launch(8'h86, PC + 64);
        check8(8'(i_fsp_flash_model.n_prog), 8'h04);
        rd_flash(22'h00137e, 8'h00);
        // A full block of 64 table writes; the pointer is brought back into the block first.
        set_ptr(22'h001380);
        for (int i = 0; i < 64; i++)
        begin
            wr(fsp_pkg::REG_LATCH, 8'(i));
            tbl(1'b1, fsp_pkg::MODE_POST_INC);
        end
        set_ptr(22'h001380);
        launch(8'h86, PC + 64);
        check8(8'(i_fsp_flash_model.n_prog), 8'h44);
        check22({6'h0, i_fsp_flash_model.last_blk}, 22'h00004e);
        // The unerased pattern b9h there is ANDed with the loaded 05h.
        rd_flash(22'h001385, 8'h01);
        // A warm reset cuts an erase short and leaves the abort flag set.
        wr(fsp_pkg::REG_UNLOCK, fsp_pkg::KEY_FIRST);
        wr(fsp_pkg::REG_UNLOCK, fsp_pkg::KEY_SECOND);
        wr(fsp_pkg::REG_CONTROL, 8'h96);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        @(posedge clock);
        #1;
        check8({7'h0, core_stall}, 8'h00);
        rd(fsp_pkg::REG_CONTROL, d);
        check8(d & 8'h0a, 8'h08);
        // A low clock enable freezes the block, so this register write is lost.
        ce <= 1'b0;
        wr(fsp_pkg::REG_PTR_MID, 8'h77);
        ce <= 1'b1;
        rd_chk(fsp_pkg::REG_PTR_MID, 8'h13);
        give_verdict();
    end
endmodule
